// [design/dspw_consts.svh]
/*
 Constants of the converter serial write port: frame layout, field
 positions, reset values and counter widths.
 Assumes it is included by bare name from the package and the modules.
*/
`ifndef DSPW_CONSTS_SVH
`define DSPW_CONSTS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define DSPW_FRAME_BITS 16
`define DSPW_CNT_W 5
`define DSPW_LAST_BIT 5'h0f
`define DSPW_MODE_HI 13
`define DSPW_MODE_LO 12
`define DSPW_CODE_HI 11
`define DSPW_CODE_LO 4
`define DSPW_CODE_W 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSPW_CODE_RST 8'h00
`define DSPW_SHREG_RST 16'h0000
`define DSPW_CNT_RST 5'h00
`define DSPW_PINS_IDLE 3'h7

`endif

// [design/dspw_pkg.sv]
/*
 Types of the converter serial write port: pin bundle, modes, frame
 states and the state records of both modules.
 Assumes dspw_consts.svh is on the include path.
*/
`include "dspw_consts.svh"

package dspw_pkg;

   // ----------------------------------------
   // Pin bundle, as seen from the device
   // ----------------------------------------
   typedef struct packed {
      logic frame_sel_n; // Frame select, active low
      logic shift_clk;   // Host shift clock
      logic ser_data;    // Serial data in
   } dspw_pins_t;

   // Output mode, two mode bits of the frame
   typedef enum logic [1:0] {
      DSPW_NORMAL  = 2'b00,
      DSPW_PD_1K   = 2'b01,
      DSPW_PD_100K = 2'b10,
      DSPW_PD_HIZ  = 2'b11
   } dspw_mode_t;

   // Frame sequencer states
   typedef enum logic [1:0] {
      DSPW_IDLE  = 2'b00,
      DSPW_SHIFT = 2'b01,
      DSPW_DONE  = 2'b10
   } dspw_fsm_t;

   // Synchroniser state
   typedef struct packed {
      dspw_pins_t s1;   // First stage, read by s2 only
      dspw_pins_t s2;
      dspw_pins_t s3;
      dspw_pins_t filt; // Settled pin levels
   } dspw_sync_t;

   // Write port state
   typedef struct packed {
      dspw_fsm_t fsm;
      logic [`DSPW_FRAME_BITS-1:0] shreg;
      logic [`DSPW_CNT_W-1:0] cnt;
      logic clk_last;
      logic [`DSPW_CODE_W-1:0] dac_code;
      dspw_mode_t mode;
      logic amp_en;
      logic pd_1k;
      logic pd_100k;
      logic pd_hiz;
      logic load_pulse;
      logic abort_pulse;
   } dspw_state_t;

endpackage

// [design/dspw_pin_sync.sv]
/*
 Three-stage synchroniser with agreement filter for the three write
 port pins. A settled level changes only when stages two and three agree.
 Assumes pins are asynchronous to core_clk and idle high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dspw_consts.svh"

module dspw_pin_sync
   import dspw_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Raw pins
   input wire dspw_pins_t pins_raw,
   // Settled pins
   output var dspw_pins_t pins_filt
);

   dspw_sync_t st;      // Registered state
   dspw_sync_t next_st; // Next state

   // Shift chain and agreement filter, per pin bit
   always_comb begin
      next_st = st;
      next_st.s1 = pins_raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < $bits(dspw_pins_t); i++) begin
         // Glitch of one sample never reaches the filter
         if (st.s2[i] == st.s3[i]) begin
            next_st.filt[i] = st.s3[i];
         end
      end
   end

   // State register; pins reset to idle high
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st <= {4{dspw_pins_t'(`DSPW_PINS_IDLE)}};
      end else begin
         st <= next_st;
      end
   end

   assign pins_filt = st.filt;

endmodule // dspw_pin_sync
`default_nettype wire

// [design/dspw_write_port.sv]
/*
 Serial write port of a single-channel 8-bit converter: frame sequencer,
 16-bit input shift register, converter code register and power-down
 mode decode.
 Assumes the host pins arrive asynchronously and that the host shift
 clock is slow enough to be seen at the core_clk rate (each level held
 at least four core_clk periods).
*/
`timescale 1ns/1ps
`default_nettype none
`include "dspw_consts.svh"

module dspw_write_port
   import dspw_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Host pins
   input wire logic frame_sel_n,
   input wire logic shift_clk,
   input wire logic ser_data,
   // Converter side
   output logic [`DSPW_CODE_W-1:0] dac_code,
   output dspw_mode_t out_mode,
   output logic amp_en,
   output logic pd_1k,
   output logic pd_100k,
   output logic pd_hiz,
   // Frame events
   output logic load_pulse,
   output logic abort_pulse
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   dspw_pins_t pins_raw;  // Raw pin bundle
   dspw_pins_t pins_filt; // Settled pin levels

   assign pins_raw = '{frame_sel_n: frame_sel_n, shift_clk: shift_clk, ser_data: ser_data};

   dspw_pin_sync u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .pins_raw(pins_raw),
      .pins_filt(pins_filt)
   );

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   dspw_state_t st;      // Registered state
   dspw_state_t next_st; // Next state
   logic clk_fall;       // Settled shift clock went high to low
   logic sel_active;     // Frame select settled low

   assign clk_fall = st.clk_last & ~pins_filt.shift_clk;
   assign sel_active = ~pins_filt.frame_sel_n;

   // Next state: shift, count, load or discard
   always_comb begin
      next_st = st;
      next_st.clk_last = pins_filt.shift_clk;
      next_st.load_pulse = 1'b0;
      next_st.abort_pulse = 1'b0;
      unique case (st.fsm)
         DSPW_IDLE: begin
            // New frame opens on select low; start clean
            if (sel_active) begin
               next_st.fsm = DSPW_SHIFT;
               next_st.cnt = `DSPW_CNT_RST;
               next_st.shreg = `DSPW_SHREG_RST;
            end
         end
         DSPW_SHIFT: begin
            if (!sel_active) begin
               // Early rise: nothing reaches code or mode
               next_st.fsm = DSPW_IDLE;
               next_st.shreg = `DSPW_SHREG_RST;
               next_st.cnt = `DSPW_CNT_RST;
               next_st.abort_pulse = 1'b1;
            end else if (clk_fall) begin
               // MSB arrives first, so shift toward the top
               next_st.shreg = {st.shreg[`DSPW_FRAME_BITS-2:0], pins_filt.ser_data};
               next_st.cnt = st.cnt + `DSPW_CNT_W'(1);
               if (st.cnt == `DSPW_LAST_BIT) begin
                  // Sixteenth edge: execute the frame
                  next_st.fsm = DSPW_DONE;
                  next_st.load_pulse = 1'b1;
                  next_st.mode = dspw_mode_t'({st.shreg[`DSPW_MODE_HI-1],
                     st.shreg[`DSPW_MODE_LO-1]});
                  // Power-down frames leave the stored code alone
                  if ({st.shreg[`DSPW_MODE_HI-1], st.shreg[`DSPW_MODE_LO-1]} == DSPW_NORMAL) begin
                     next_st.dac_code = st.shreg[`DSPW_CODE_HI-1:`DSPW_CODE_LO-1];
                  end
               end
            end
         end
         DSPW_DONE: begin
            // Extra edges ignored until select goes high
            if (!sel_active) begin
               next_st.fsm = DSPW_IDLE;
            end
         end
         default: begin
            // Illegal code: recover to idle
            next_st.fsm = DSPW_IDLE;
         end
      endcase
      // Mode decode to output stage controls
      next_st.amp_en = (next_st.mode == DSPW_NORMAL);
      next_st.pd_1k = (next_st.mode == DSPW_PD_1K);
      next_st.pd_100k = (next_st.mode == DSPW_PD_100K);
      next_st.pd_hiz = (next_st.mode == DSPW_PD_HIZ);
   end

   // State register; code cleared and amplifier in normal mode
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st.fsm <= DSPW_IDLE;
         st.shreg <= `DSPW_SHREG_RST;
         st.cnt <= `DSPW_CNT_RST;
         st.clk_last <= 1'b1;
         st.dac_code <= `DSPW_CODE_RST;
         st.mode <= DSPW_NORMAL;
         st.amp_en <= 1'b1;
         st.pd_1k <= 1'b0;
         st.pd_100k <= 1'b0;
         st.pd_hiz <= 1'b0;
         st.load_pulse <= 1'b0;
         st.abort_pulse <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------
   // Code is passed unchanged: straight binary, 00 zero, ff full scale
   assign dac_code = st.dac_code;
   assign out_mode = st.mode;
   assign amp_en = st.amp_en;
   assign pd_1k = st.pd_1k;
   assign pd_100k = st.pd_100k;
   assign pd_hiz = st.pd_hiz;
   assign load_pulse = st.load_pulse;
   assign abort_pulse = st.abort_pulse;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Each of the first fifteen falling edges of a frame adds one bit
   property p_count_on_fall;
      @(posedge core_clk) disable iff (srst)
      (st.fsm == DSPW_SHIFT && sel_active && clk_fall && st.cnt != `DSPW_LAST_BIT)
         |=> (st.cnt == $past(st.cnt) + `DSPW_CNT_W'(1))
         && st.shreg[0] == $past(pins_filt.ser_data);
   endproperty
   a_count_on_fall: assert property (p_count_on_fall)
      else $error("bit not shifted on fall");

   // No shifting without frame select low
   property p_no_shift_idle;
      @(posedge core_clk) disable iff (srst)
      (st.fsm == DSPW_IDLE && !sel_active) |=> st.fsm == DSPW_IDLE && $stable(st.dac_code);
   endproperty
   a_no_shift_idle: assert property (p_no_shift_idle)
      else $error("activity without select");

   // Sixteenth edge gives a load pulse next cycle
   property p_load_on_last;
      @(posedge core_clk) disable iff (srst)
      (st.fsm == DSPW_SHIFT && sel_active && clk_fall && st.cnt == `DSPW_LAST_BIT)
         |=> load_pulse && st.fsm == DSPW_DONE;
   endproperty
   a_load_on_last: assert property (p_load_on_last) else $error("no load on last edge");

   // Code changes only with a load
   property p_code_needs_load;
      @(posedge core_clk) disable iff (srst)
      $changed(dac_code) |-> load_pulse && out_mode == DSPW_NORMAL;
   endproperty
   a_code_needs_load: assert property (p_code_needs_load)
      else $error("code changed without load");

   // Aborted frame: shift register cleared, code and mode kept
   property p_abort;
      @(posedge core_clk) disable iff (srst)
      (st.fsm == DSPW_SHIFT && !sel_active)
         |=> abort_pulse && st.shreg == `DSPW_SHREG_RST && $stable(dac_code) && $stable(out_mode)
         ##1 st.fsm == DSPW_IDLE;
   endproperty
   a_abort: assert property (p_abort) else $error("aborted frame took effect");

   // Loaded fields come from the documented frame bits
   property p_fields;
      @(posedge core_clk) disable iff (srst)
      load_pulse |-> out_mode == st.shreg[`DSPW_MODE_HI:`DSPW_MODE_LO]
         && (out_mode != DSPW_NORMAL || dac_code == st.shreg[`DSPW_CODE_HI:`DSPW_CODE_LO]);
   endproperty
   a_fields: assert property (p_fields) else $error("field mismatch at load");

   // Output stage controls follow the mode
   property p_decode;
      @(posedge core_clk) disable iff (srst)
      load_pulse |-> ##1 (amp_en == (out_mode == DSPW_NORMAL))
         && (pd_1k == (out_mode == DSPW_PD_1K))
         && (pd_100k == (out_mode == DSPW_PD_100K)) && (pd_hiz == (out_mode == DSPW_PD_HIZ));
   endproperty
   a_decode: assert property (p_decode) else $error("mode decode wrong");

   // After reset the code reads zero in normal mode
   property p_reset_zero;
      @(posedge core_clk) disable iff (srst)
      $fell(srst) |-> dac_code == `DSPW_CODE_RST && out_mode == DSPW_NORMAL && amp_en;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("code not zero after reset");

   // Power-down load keeps the previous code
   property p_pd_keeps;
      @(posedge core_clk) disable iff (srst)
      (load_pulse && out_mode != DSPW_NORMAL) |-> $stable(dac_code);
   endproperty
   a_pd_keeps: assert property (p_pd_keeps) else $error("power-down changed code");

   // Completed frame ignores edges until select rises
   property p_done_hold;
      @(posedge core_clk) disable iff (srst)
      (st.fsm == DSPW_DONE && sel_active)
         |=> st.fsm == DSPW_DONE && $stable(st.shreg) && !load_pulse;
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("edge taken after frame");

endmodule // dspw_write_port
`default_nettype wire

// [testbench/dspw_host_model.sv]
/*
 Host-side serial master model for the converter write port.
 Assumes the bench requests one frame at a time and waits for busy low.
*/
`timescale 1ns/1ps
`default_nettype none

module dspw_host_model (
   // Clock
   input wire logic core_clk,
   // Frame request
   input wire logic go,
   input wire logic [15:0] word,
   input wire logic [4:0] nbits,
   output logic busy,
   // Pins towards the port
   output logic frame_sel_n,
   output logic shift_clk,
   output logic ser_data
);
   // ----------------------------------------
   // Pin timing
   // ----------------------------------------
   // Five cycles per level: the port oversamples, so slow is the only safe pace
   localparam int HOLD = 5;
   int i; // Bit index within the frame

   task automatic hold();
      repeat (HOLD) @(posedge core_clk);
   endtask

   // Idle: select high, clock parked high, data arbitrary
   initial begin
      busy = 1'b0;
      frame_sel_n = 1'b1;
      shift_clk = 1'b1;
      ser_data = 1'b0;
   end

   // One frame per request; nbits below 16 aborts, above 16 adds spare edges
   always @(posedge core_clk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         frame_sel_n <= 1'b0;
         hold();
         for (i = 0; i < nbits; i++) begin
            ser_data <= word[15 - (i % 16)];
            hold();
            shift_clk <= 1'b0;
            hold();
            shift_clk <= 1'b1;
         end
         hold();
         // Released data is not held: invert so no stale level passes
         frame_sel_n <= 1'b1;
         ser_data <= ~ser_data;
         hold();
         hold();
         busy <= 1'b0;
      end
   end
endmodule // dspw_host_model

`default_nettype wire

// [testbench/testbench.sv]
/*
 Self-checking bench for the converter write port: host model drives
 frames, a monitor compares each pulse against the oldest expectation.
 Assumes the design package and constants are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
   import dspw_pkg::*;
;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic go = 1'b0;
   logic [15:0] word = 16'h0000;
   logic [4:0] nbits = 5'h00;
   logic busy, frame_sel_n, shift_clk, ser_data;
   logic [7:0] dac_code;
   dspw_mode_t out_mode;
   logic amp_en, pd_1k, pd_100k, pd_hiz, load_pulse, abort_pulse;
   logic [14:0] obs; // Observed outputs packed for comparison
   logic [14:0] expq[$]; // Expected results, oldest first
   logic [7:0] cur_code = 8'h00; // Model of stored code
   logic [1:0] cur_mode = 2'h0; // Model of stored mode
   logic [31:0] rng = 32'he389ff32;
   logic [15:0] w;
   int miscompares = 0;
   int tests_run = 0;
   int m;

   always #50 core_clk = ~core_clk;

   assign obs = {abort_pulse, pd_hiz, pd_100k, pd_1k, amp_en, out_mode, dac_code};

   dspw_host_model host (.core_clk(core_clk), .go(go), .word(word), .nbits(nbits),
      .busy(busy), .frame_sel_n(frame_sel_n), .shift_clk(shift_clk), .ser_data(ser_data));

   dspw_write_port uut (.core_clk(core_clk), .srst(srst), .frame_sel_n(frame_sel_n),
      .shift_clk(shift_clk), .ser_data(ser_data), .dac_code(dac_code),
      .out_mode(out_mode), .amp_en(amp_en), .pd_1k(pd_1k), .pd_100k(pd_100k),
      .pd_hiz(pd_hiz), .load_pulse(load_pulse), .abort_pulse(abort_pulse));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // Expected outputs: decodes follow the mode one-hot
   function automatic logic [14:0] pack(input logic ab, input logic [1:0] md,
         input logic [7:0] cd);
      return {ab, md == 2'h3, md == 2'h2, md == 2'h1, md == 2'h0, md, cd};
   endfunction

   task automatic cmp_res(input logic [14:0] got, input logic [14:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("counts: %0d compared, %0d wrong", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Note the expectation, send one frame, wait for the host to finish
   task automatic frame(input logic [15:0] fw, input logic [4:0] n);
      int k;
      if (n < 5'h10) begin
         expq.push_back(pack(1'b1, cur_mode, cur_code));
      end else begin
         if (fw[13:12] == 2'h0) cur_code = fw[11:4];
         cur_mode = fw[13:12];
         expq.push_back(pack(1'b0, cur_mode, cur_code));
      end
      word <= fw;
      nbits <= n;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      @(posedge core_clk);
      k = 0;
      while (busy !== 1'b0 && k < 1000) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= 1000) begin
         miscompares++;
         $display("unexpected at %0t got %h exp %h", $time, busy, 1'h0);
         complete_run();
      end
   endtask

   // ----------------------------------------
   // Monitor: each pulse takes the oldest note
   // ----------------------------------------
   always @(negedge core_clk) begin
      if (!srst && (load_pulse === 1'b1 || abort_pulse === 1'b1)) begin
         if (expq.size() == 0) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, obs, 15'h0000);
         end else begin
            cmp_res(obs, expq.pop_front());
         end
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      repeat (4) @(negedge core_clk);
      cmp_res(obs, pack(1'b0, 2'h0, 8'h00));
      $display("test reset done");
      // Requests start on a rising edge
      @(posedge core_clk);
      frame(16'hcff0, 5'h0f);
      frame(16'h0000, 5'h01);
      $display("test abort done");
      // Full scale after an abort: stale bits must not leak in
      frame(16'hcfff, 5'h10);
      for (m = 1; m < 4; m++) begin
         rng = xorshift(rng);
         w = rng[15:0];
         w[13:12] = m[1:0];
         frame(w, 5'h10);
      end
      frame(16'h0000, 5'h10);
      $display("test modes done");
      rng = xorshift(rng);
      w = rng[15:0] & 16'hcfff;
      frame(w, 5'h14);
      $display("test spare edges done");
      for (m = 0; m < 6; m++) begin
         rng = xorshift(rng);
         frame(rng[15:0], 5'h10);
      end
      $display("test random done");
      // Reset in mid-run: code and mode fall back, power-down keeps zero code
      srst <= 1'b1;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      cur_code = 8'h00;
      cur_mode = 2'h0;
      repeat (4) @(negedge core_clk);
      cmp_res(obs, pack(1'b0, 2'h0, 8'h00));
      @(posedge core_clk);
      frame(16'h2ff0, 5'h10);
      frame(16'h0a50, 5'h10);
      $display("test mid reset done");
      repeat (20) @(negedge core_clk);
      // Notes never matched by a pulse count as misses
      if (expq.size() != 0) begin
         miscompares++;
         $display("unexpected at %0t got %h exp %h", $time, expq.size(), 0);
      end
      complete_run();
   end
endmodule // testbench

`default_nettype wire
